/* design/pmit_idle_timer.sv */
// pmit_idle_timer: one reloadable down counter with single expiry pulse
// assumes: tick is a one-cycle pulse from the shared time base
`timescale 1ns/1ps
module pmit_idle_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // control
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic         reload,
  input  wire logic [W-1:0] load,
  // status
  output logic              expire,
  output logic [W-1:0]      count
);
  import pmit_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         armed;
    logic         expire;
  } pmit_tmr_state_type;
  pmit_tmr_state_type s_ff;
  pmit_tmr_state_type nxt_s;
  always_comb begin
    nxt_s        = s_ff;
    nxt_s.expire = 1'b0;
    if (reload) begin
      nxt_s.cnt   = load;
      nxt_s.armed = 1'b1;
    end else if (run && tick && s_ff.armed) begin
      if (s_ff.cnt <= W'(1)) begin
        nxt_s.cnt    = '0;
        nxt_s.armed  = 1'b0;
        nxt_s.expire = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt - W'(1);
      end
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign expire = s_ff.expire;
  assign count  = s_ff.cnt;
  property p_hold;
    @(posedge clock) disable iff (!nrst) !run && !reload |=> $stable(s_ff.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("idle count moved while stopped");
  property p_last;
    @(posedge clock) disable iff (!nrst) s_ff.armed && run && tick && !reload && s_ff.cnt == W'(1) |=> expire;
  endproperty
  a_last: assert property (p_last) else $error("no expiry at zero");
  property p_once;
    @(posedge clock) disable iff (!nrst) expire |=> !expire ##1 (!expire || $past(reload, 2));
  endproperty
  a_once: assert property (p_once) else $error("expiry repeated");
endmodule : pmit_idle_timer

/* design/pmit_pkg.sv */
// pmit_pkg: offsets, fields, ranges and timing of the idle timer block
// assumes: byte-wide configuration port, 250 MHz bridge clock
package pmit_pkg;
  // ----------------------------------------
  // configuration offsets
  // ----------------------------------------
  localparam logic [7:0]      REG_ENABLE_1    = 8'h80;
  localparam logic [7:0]      REG_IDLE_EN_2   = 8'h81;
  localparam logic [7:0]      REG_STATUS_2    = 8'h85;
  localparam logic [7:0]      REG_IRQ_SPD_CNT = 8'h8C;
  localparam logic [7:0]      REG_VID_SPD_CNT = 8'h8D;
  localparam logic [7:0]      REG_PORT_SEL    = 8'h93;
  localparam logic [7:0][7:0] TMR_CNT_OFS     = {8'hA6, 8'hA4, 8'hA2, 8'hA0, 8'h9E, 8'h9C, 8'h9A, 8'h98};
  localparam logic [2:0][7:0] USR_BASE_OFS    = {8'hC8, 8'hC4, 8'hC0};
  localparam logic [2:0][7:0] USR_CTL_OFS     = {8'hCE, 8'hCD, 8'hCC};
  localparam logic [7:0]      REG_RESET       = 8'h00;
  localparam logic [7:0]      EN1_WR_MASK     = 8'h1B;
  // ----------------------------------------
  // field positions and codes
  // ----------------------------------------
  localparam int              EN1_VID_SPD     = 4;
  localparam int              EN1_IRQ_SPD     = 3;
  localparam int              EN1_TRAPS       = 1;
  localparam int              EN1_TIMERS      = 0;
  localparam int              SEL_HD          = 5;
  localparam int              PSER_VIDEO      = 0;
  localparam int              USR_CTL_EN      = 7;
  localparam int              USR_MSK_W       = 5;
  localparam logic [1:0]      COM1_TO_KBD     = 2'b10;
  localparam logic [1:0]      COM2_TO_KBD     = 2'b11;
  localparam int              T_HDD           = 0;
  localparam int              T_FDD           = 1;
  localparam int              T_PAR           = 2;
  localparam int              T_KBD           = 3;
  localparam int              T_USR1          = 4;
  localparam int              T_VID           = 7;
  // ----------------------------------------
  // i/o ranges, each {low, high}
  // ----------------------------------------
  localparam logic [31:0]     COM1_RNG        = {16'h03F8, 16'h03FF};
  localparam logic [31:0]     COM2_RNG        = {16'h02F8, 16'h02FF};
  localparam logic [5:0][31:0] PAR_RNG = {{16'h0378, 16'h037F}, {16'h0778, 16'h077A}, {16'h0278, 16'h027F},
                                          {16'h0678, 16'h067A}, {16'h03E8, 16'h03EF}, {16'h02E8, 16'h02EF}};
  localparam logic [5:0][31:0] FDD_RNG = {{16'h03F2, 16'h03F5}, {16'h03F7, 16'h03F7}, {16'h0372, 16'h0375},
                                          {16'h0377, 16'h0377}, {16'h03F2, 16'h03F5}, {16'h0372, 16'h0375}};
  localparam logic [5:0][31:0] KBD_RNG = {{16'h0060, 16'h0060}, {16'h0064, 16'h0064}, {16'h0060, 16'h0060},
                                          {16'h0064, 16'h0064}, {16'h0060, 16'h0060}, {16'h0064, 16'h0064}};
  localparam logic [5:0][31:0] HD0_RNG = {{16'h01F0, 16'h01F7}, {16'h03F6, 16'h03F6}, {16'h01F0, 16'h01F7},
                                          {16'h03F6, 16'h03F6}, {16'h01F0, 16'h01F7}, {16'h03F6, 16'h03F6}};
  localparam logic [5:0][31:0] HD1_RNG = {{16'h0170, 16'h0177}, {16'h0376, 16'h0376}, {16'h0170, 16'h0177},
                                          {16'h0376, 16'h0376}, {16'h0170, 16'h0177}, {16'h0376, 16'h0376}};
  localparam logic [31:0]     VGA_IO_RNG      = {16'h03B0, 16'h03DF};
  localparam logic [31:0]     VGA_MEM_LO      = 32'h000A_0000;
  localparam logic [31:0]     VGA_MEM_HI      = 32'h000B_7FFF;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int              CLOCK_PERIOD_NS = 4;
  localparam int              TICK_TIME_NS    = 1000000;
  localparam int              TICK_CYCLES     = TICK_TIME_NS / CLOCK_PERIOD_NS;
endpackage : pmit_pkg

/* design/pmit_speedup.sv */
// pmit_speedup: holds off clock throttling for a programmed tick count
// assumes: trigger and tick are one-cycle pulses on the same clock
`timescale 1ns/1ps
module pmit_speedup (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // control
  input  wire logic       enable,
  input  wire logic       trigger,
  input  wire logic       tick,
  input  wire logic [7:0] load,
  // status
  output logic            hold
);
  import pmit_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic       hold;
  } pmit_spd_state_type;
  pmit_spd_state_type s_ff;
  pmit_spd_state_type nxt_s;
  always_comb begin
    nxt_s = s_ff;
    if (!enable) begin
      nxt_s.cnt = '0;
    end else if (trigger) begin
      nxt_s.cnt = load;
    end else if (tick && s_ff.cnt != 8'h00) begin
      nxt_s.cnt = s_ff.cnt - 8'h01;
    end
    nxt_s.hold = (nxt_s.cnt != 8'h00);
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign hold = s_ff.hold;
  property p_off;
    @(posedge clock) disable iff (!nrst) !enable |=> !hold;
  endproperty
  a_off: assert property (p_off) else $error("speedup held while disabled");
endmodule : pmit_speedup

/* design/pmit_top.sv */
// pmit_top: idle timer enables, reload decode, global gates and speedup
// assumes: access, serial status, irq and trap inputs are on CLOCK
`timescale 1ns/1ps
//
// Contract
// - video timer runs, expiry raises SMI
// - serial status bit 0 reloads video timer
// - third user range timer and reload
// - second user range timer and reload
// - first user range timer and reload
// - keyboard ports reload keyboard/mouse timer
// - COM1/COM2 join keyboard ranges by select
// - printer and COM3/COM4 reload parallel timer
// - COM1/COM2 leave parallel ranges by select
// - floppy ports reload floppy timer
// - hard disk ranges chosen by select bit
// - expiry sets top and second status
// - global trap enable gates device traps
// - audio traps ignore global trap enable
// - global timer enable gates all timers
// - global re-enable resumes, does not reload
// - video activity suspends throttling for count
// - VGA io and memory trigger video speedup
// - unmasked IRQ or SMI triggers speedup
module pmit_top #(
  parameter int TICK_CYCLES = pmit_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  // configuration port
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_WDATA,
  output logic [7:0]       CFG_RDATA,
  // host access monitor
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_IO,
  input  wire logic [31:0] ACC_ADDR,
  // processor serial status
  input  wire logic        PROCESSOR_SERIAL_VALID,
  input  wire logic [7:0]  PROCESSOR_SERIAL_STATUS,
  // interrupt activity
  input  wire logic [15:0] IRQ_LINES,
  input  wire logic [15:0] IRQ_MASK,
  input  wire logic        SMI_ACTIVE,
  // trap hits
  input  wire logic [7:0]  DEVICE_TRAP_HIT,
  input  wire logic        AUDIO_TRAP_HIT,
  // results
  output logic             IDLE_SMI,
  output logic             TRAP_SMI,
  output logic             TRAPS_ENABLED,
  output logic             THROTTLE_HOLD
);
  import pmit_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  typedef struct packed {
    logic [7:0]       en1;
    logic [7:0]       en2;
    logic [7:0]       sel;
    logic [7:0]       vid_cnt;
    logic [7:0]       irq_cnt;
    logic [7:0]       status2;
    logic [7:0]       rdata;
    logic [7:0]       en_rise;
    logic [7:0][7:0]  tmr_cnt;
    logic [2:0][15:0] usr_base;
    logic [2:0][7:0]  usr_ctl;
    logic [TW-1:0]    div;
    logic             tick;
    logic             idle_smi;
    logic             trap_smi;
    logic             irq_lvl;
  } pmit_top_state_type;

  pmit_top_state_type s_ff;
  pmit_top_state_type nxt_s;

  logic [7:0]  hit;
  logic [7:0]  exp;
  logic [7:0][7:0] tmr_now;
  logic [7:0]  reload;
  logic [7:0]  rd_val;
  logic        io;
  logic        com1;
  logic        com2;
  logic        vid_trig;
  logic        irq_now;
  logic        irq_trig;
  logic        vid_hold;
  logic        irq_hold;
  logic [15:0] a;

  function automatic logic in_rng(input logic [15:0] ad, input logic [31:0] r);
    return (ad >= r[31:16]) && (ad <= r[15:0]);
  endfunction : in_rng

  function automatic logic in_set(input logic [15:0] ad, input logic [5:0][31:0] t);
    logic m;
    m = 1'b0;
    for (int i = 0; i < 6; i++) begin
      m = m | in_rng(ad, t[i]);
    end
    return m;
  endfunction : in_set

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  assign a    = ACC_ADDR[15:0];
  assign io   = ACC_VALID && ACC_IO;
  assign com1 = io && in_rng(a, COM1_RNG);
  assign com2 = io && in_rng(a, COM2_RNG);

  always_comb begin
    hit        = '0;
    hit[T_VID] = PROCESSOR_SERIAL_VALID && PROCESSOR_SERIAL_STATUS[PSER_VIDEO];
    hit[T_KBD] = (io && in_set(a, KBD_RNG))
                 || (com1 && s_ff.sel[1:0] == COM1_TO_KBD)
                 || (com2 && s_ff.sel[1:0] == COM2_TO_KBD);
    hit[T_PAR] = (io && in_set(a, PAR_RNG))
                 || (com1 && s_ff.sel[1:0] != COM1_TO_KBD)
                 || (com2 && s_ff.sel[1:0] != COM2_TO_KBD);
    hit[T_FDD] = io && in_set(a, FDD_RNG);
    hit[T_HDD] = io && (s_ff.sel[SEL_HD] ? in_set(a, HD1_RNG) : in_set(a, HD0_RNG));
    for (int k = 0; k < 3; k++) begin
      hit[T_USR1 + k] = io && s_ff.usr_ctl[k][USR_CTL_EN]
                        && (((a ^ s_ff.usr_base[k]) & ~{11'h000, s_ff.usr_ctl[k][USR_MSK_W-1:0]}) == 16'h0000);
    end
  end

  assign vid_trig = hit[T_VID]
                    || (io && in_rng(a, VGA_IO_RNG))
                    || (ACC_VALID && !ACC_IO && ACC_ADDR >= VGA_MEM_LO && ACC_ADDR <= VGA_MEM_HI);
  assign irq_now  = (|(IRQ_LINES & ~IRQ_MASK)) || SMI_ACTIVE || s_ff.idle_smi || s_ff.trap_smi;
  assign irq_trig = irq_now && !s_ff.irq_lvl;
  assign reload   = hit | s_ff.en_rise;

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always_comb begin
    rd_val = REG_RESET;
    unique case (CFG_ADDR)
      REG_ENABLE_1:    rd_val = s_ff.en1;
      REG_IDLE_EN_2:   rd_val = s_ff.en2;
      REG_STATUS_2:    rd_val = s_ff.status2;
      REG_IRQ_SPD_CNT: rd_val = s_ff.irq_cnt;
      REG_VID_SPD_CNT: rd_val = s_ff.vid_cnt;
      REG_PORT_SEL:    rd_val = s_ff.sel;
      default:         rd_val = REG_RESET;
    endcase
    for (int i = 0; i < 8; i++) begin
      if (CFG_ADDR == TMR_CNT_OFS[i]) begin
        rd_val = s_ff.tmr_cnt[i];
      end
    end
    for (int k = 0; k < 3; k++) begin
      if (CFG_ADDR == USR_BASE_OFS[k]) begin
        rd_val = s_ff.usr_base[k][7:0];
      end
      if (CFG_ADDR == 8'(USR_BASE_OFS[k] + 8'h01)) begin
        rd_val = s_ff.usr_base[k][15:8];
      end
      if (CFG_ADDR == USR_CTL_OFS[k]) begin
        rd_val = s_ff.usr_ctl[k];
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    // time base
    if (s_ff.div == TW'(TICK_CYCLES - 1)) begin
      nxt_s.div  = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.div  = s_ff.div + TW'(1);
      nxt_s.tick = 1'b0;
    end
    // register writes
    if (CFG_WR) begin
      unique case (CFG_ADDR)
        REG_ENABLE_1:    nxt_s.en1 = CFG_WDATA & EN1_WR_MASK;
        REG_IDLE_EN_2:   nxt_s.en2 = CFG_WDATA;
        REG_IRQ_SPD_CNT: nxt_s.irq_cnt = CFG_WDATA;
        REG_VID_SPD_CNT: nxt_s.vid_cnt = CFG_WDATA;
        REG_PORT_SEL:    nxt_s.sel = CFG_WDATA;
        default:         nxt_s.sel = s_ff.sel;
      endcase
      for (int i = 0; i < 8; i++) begin
        if (CFG_ADDR == TMR_CNT_OFS[i]) begin
          nxt_s.tmr_cnt[i] = CFG_WDATA;
        end
      end
      for (int k = 0; k < 3; k++) begin
        if (CFG_ADDR == USR_BASE_OFS[k]) begin
          nxt_s.usr_base[k][7:0] = CFG_WDATA;
        end
        if (CFG_ADDR == 8'(USR_BASE_OFS[k] + 8'h01)) begin
          nxt_s.usr_base[k][15:8] = CFG_WDATA;
        end
        if (CFG_ADDR == USR_CTL_OFS[k]) begin
          nxt_s.usr_ctl[k] = CFG_WDATA;
        end
      end
    end
    // a timer starts from its count when its enable is turned on
    nxt_s.en_rise = nxt_s.en2 & ~s_ff.en2;
    // read data and read-to-clear status, a new expiry wins
    if (CFG_RD) begin
      nxt_s.rdata = rd_val;
    end
    if (CFG_RD && CFG_ADDR == REG_STATUS_2) begin
      nxt_s.status2 = exp;
    end else begin
      nxt_s.status2 = s_ff.status2 | exp;
    end
    nxt_s.idle_smi = |exp;
    nxt_s.trap_smi = (s_ff.en1[EN1_TRAPS] && |DEVICE_TRAP_HIT)
                     || AUDIO_TRAP_HIT;
    nxt_s.irq_lvl  = irq_now;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // idle timers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_tmr
      pmit_idle_timer #(
        .W (8)
      ) u_tmr (
        .clock  (CLOCK),
        .nrst   (NRST),
        .tick   (s_ff.tick),
        .run    (s_ff.en2[g] && s_ff.en1[EN1_TIMERS]),
        .reload (reload[g]),
        .load   (s_ff.tmr_cnt[g]),
        .expire (exp[g]),
        .count  (tmr_now[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // speedup
  // ----------------------------------------
  pmit_speedup u_vid_spd (
    .clock   (CLOCK),
    .nrst    (NRST),
    .enable  (s_ff.en1[EN1_VID_SPD]),
    .trigger (vid_trig),
    .tick    (s_ff.tick),
    .load    (s_ff.vid_cnt),
    .hold    (vid_hold)
  );

  pmit_speedup u_irq_spd (
    .clock   (CLOCK),
    .nrst    (NRST),
    .enable  (s_ff.en1[EN1_IRQ_SPD]),
    .trigger (irq_trig),
    .tick    (s_ff.tick),
    .load    (s_ff.irq_cnt),
    .hold    (irq_hold)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign CFG_RDATA     = s_ff.rdata;
  assign IDLE_SMI      = s_ff.idle_smi;
  assign TRAP_SMI      = s_ff.trap_smi;
  assign TRAPS_ENABLED = s_ff.en1[EN1_TRAPS];
  assign THROTTLE_HOLD = vid_hold || irq_hold;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_status;
    @(posedge CLOCK) disable iff (!NRST) (|exp) |=> IDLE_SMI && ((s_ff.status2 & $past(exp)) == $past(exp));
  endproperty
  a_status: assert property (p_status) else $error("expiry not reported");

  property p_gate;
    @(posedge CLOCK) disable iff (!NRST) !s_ff.en1[EN1_TIMERS] && !$past(s_ff.en1[EN1_TIMERS]) |-> exp == 8'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("timer expired while globally off");

  property p_vid_en;
    @(posedge CLOCK) disable iff (!NRST) !s_ff.en2[T_VID] && !$past(s_ff.en2[T_VID]) |-> !exp[T_VID];
  endproperty
  a_vid_en: assert property (p_vid_en) else $error("video timer expired while off");

  property p_trap;
    @(posedge CLOCK) disable iff (!NRST) !AUDIO_TRAP_HIT
      |=> TRAP_SMI == $past(s_ff.en1[EN1_TRAPS] && |DEVICE_TRAP_HIT);
  endproperty
  a_trap: assert property (p_trap) else $error("device trap not gated");

  property p_audio;
    @(posedge CLOCK) disable iff (!NRST) AUDIO_TRAP_HIT |=> TRAP_SMI;
  endproperty
  a_audio: assert property (p_audio) else $error("audio trap lost");

  property p_com1;
    @(posedge CLOCK) disable iff (!NRST) com1 |-> (hit[T_KBD] != hit[T_PAR])
      && (hit[T_KBD] == (s_ff.sel[1:0] == COM1_TO_KBD));
  endproperty
  a_com1: assert property (p_com1) else $error("COM1 range misrouted");

  property p_com2;
    @(posedge CLOCK) disable iff (!NRST) com2 |-> (hit[T_KBD] != hit[T_PAR])
      && (hit[T_KBD] == (s_ff.sel[1:0] == COM2_TO_KBD));
  endproperty
  a_com2: assert property (p_com2) else $error("COM2 range misrouted");

  property p_vga;
    @(posedge CLOCK) disable iff (!NRST) ACC_VALID && !ACC_IO && ACC_ADDR == VGA_MEM_LO |-> vid_trig;
  endproperty
  a_vga: assert property (p_vga) else $error("VGA memory access missed");

  property p_vid_spd;
    @(posedge CLOCK) disable iff (!NRST) vid_trig && s_ff.en1[EN1_VID_SPD] && s_ff.vid_cnt != 8'h00 |=> THROTTLE_HOLD;
  endproperty
  a_vid_spd: assert property (p_vid_spd) else $error("video speedup not held");

  property p_irq_spd;
    @(posedge CLOCK) disable iff (!NRST) irq_trig && s_ff.en1[EN1_IRQ_SPD] && s_ff.irq_cnt != 8'h00 |=> THROTTLE_HOLD;
  endproperty
  a_irq_spd: assert property (p_irq_spd) else $error("irq speedup not held");

  property p_reload;
    @(posedge CLOCK) disable iff (!NRST) hit[T_FDD] |=> tmr_now[T_FDD] == $past(s_ff.tmr_cnt[T_FDD]);
  endproperty
  a_reload: assert property (p_reload) else $error("floppy reload ignored");
endmodule : pmit_top

/* tb/pm_idle_timer_enables_test.sv */
// pm_idle_timer_enables_test: self-checking bench of the idle timer block
// assumes: design sources and pmit_host_model compiled before
`timescale 1ns/1ps
module pm_idle_timer_enables_test;
  import pmit_pkg::*;
  logic        CLOCK, NRST, CFG_WR, CFG_RD, ACC_VALID, ACC_IO, PROCESSOR_SERIAL_VALID;
  logic        SMI_ACTIVE, AUDIO_TRAP_HIT, IDLE_SMI, TRAP_SMI, TRAPS_ENABLED, THROTTLE_HOLD;
  logic [7:0]  CFG_ADDR, CFG_WDATA, CFG_RDATA, PROCESSOR_SERIAL_STATUS, DEVICE_TRAP_HIT;
  logic [31:0] ACC_ADDR;
  logic [15:0] IRQ_LINES, IRQ_MASK;
  logic [7:0]  d;
  logic        hit;
  int          mismatches, n_tests;
  pmit_top #(.TICK_CYCLES(4)) pmit_top_i (.CLOCK, .NRST, .CFG_ADDR, .CFG_WR, .CFG_RD, .CFG_WDATA,
    .CFG_RDATA, .ACC_VALID, .ACC_IO, .ACC_ADDR, .PROCESSOR_SERIAL_VALID, .PROCESSOR_SERIAL_STATUS,
    .IRQ_LINES, .IRQ_MASK, .SMI_ACTIVE, .DEVICE_TRAP_HIT, .AUDIO_TRAP_HIT, .IDLE_SMI, .TRAP_SMI,
    .TRAPS_ENABLED, .THROTTLE_HOLD);
  pmit_host_model pmit_host_model_i (.clock(CLOCK), .idle_smi(IDLE_SMI), .acc_valid(ACC_VALID),
    .acc_io(ACC_IO), .acc_addr(ACC_ADDR), .ser_valid(PROCESSOR_SERIAL_VALID),
    .ser_status(PROCESSOR_SERIAL_STATUS));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task cfg_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge CLOCK);
    CFG_ADDR  = a;
    CFG_WDATA = v;
    CFG_WR    = 1'b1;
    @(negedge CLOCK);
    CFG_WR = 1'b0;
  endtask : cfg_wr
  task cfg_rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge CLOCK);
    CFG_ADDR = a;
    CFG_RD   = 1'b1;
    @(negedge CLOCK);
    CFG_RD = 1'b0;
    v = CFG_RDATA;
  endtask : cfg_rd
  task wait_smi(input int bound, output logic h);
    int c0;
    c0 = pmit_host_model_i.n_idle_smi;
    h  = 1'b0;
    for (int i = 0; i < bound && !h; i++) begin
      @(negedge CLOCK);
      h = (pmit_host_model_i.n_idle_smi != c0);
    end
  endtask : wait_smi
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task test_regs;
    cfg_rd(REG_IDLE_EN_2, d); check(d, 8'h00, "en2 reset");
    cfg_rd(REG_STATUS_2, d); check(d, 8'h00, "status reset");
    cfg_rd(8'h7F, d); check(d, 8'h00, "unmapped read");
    cfg_wr(REG_ENABLE_1, 8'hFF);
    cfg_rd(REG_ENABLE_1, d); check(d, EN1_WR_MASK, "en1 writable bits");
    cfg_wr(REG_IDLE_EN_2, 8'hA5);
    cfg_rd(REG_IDLE_EN_2, d); check(d, 8'hA5, "en2 read back");
    cfg_wr(REG_IDLE_EN_2, 8'h00);
    cfg_wr(REG_ENABLE_1, 8'h01);
    $display("test regs done");
  endtask : test_regs
  task test_expiry;
    for (int i = 0; i < 8; i++) begin
      cfg_rd(REG_STATUS_2, d);
      cfg_wr(TMR_CNT_OFS[i], 8'h02);
      cfg_wr(REG_IDLE_EN_2, 8'h01 << i);
      wait_smi(40, hit); check(8'(hit), 8'h01, "expiry smi");
      cfg_rd(REG_STATUS_2, d); check(d, 8'h01 << i, "second level status");
      wait_smi(40, hit); check(8'(hit), 8'h00, "single expiry");
      cfg_wr(REG_IDLE_EN_2, 8'h00);
    end
    $display("test expiry done");
  endtask : test_expiry
  task reload_case(input int t, input logic [31:0] a, input logic ser, input logic [7:0] sel,
                   input logic exp);
    int c0;
    cfg_wr(REG_PORT_SEL, sel);
    cfg_wr(TMR_CNT_OFS[t], 8'h03);
    cfg_wr(REG_IDLE_EN_2, 8'h01 << t);
    c0 = pmit_host_model_i.n_idle_smi;
    repeat (12) begin
      pmit_host_model_i.access(a, 1'b1, ser);
      repeat (2) @(negedge CLOCK);
    end
    check(8'(pmit_host_model_i.n_idle_smi == c0), 8'(exp), "held by accesses");
    wait_smi(40, hit); check(8'(hit), 8'(exp), "expiry after accesses stop");
    cfg_wr(REG_IDLE_EN_2, 8'h00);
  endtask : reload_case
  task test_reload;
    reload_case(T_VID, 32'h0, 1'b1, 8'h00, 1'b1);
    reload_case(T_KBD, 32'h64, 1'b0, 8'h00, 1'b1);
    reload_case(T_KBD, 32'h3F8, 1'b0, 8'h02, 1'b1);
    reload_case(T_KBD, 32'h2F8, 1'b0, 8'h02, 1'b0);
    reload_case(T_PAR, 32'h378, 1'b0, 8'h00, 1'b1);
    reload_case(T_PAR, 32'h2F8, 1'b0, 8'h02, 1'b1);
    reload_case(T_PAR, 32'h3F8, 1'b0, 8'h02, 1'b0);
    reload_case(T_FDD, 32'h372, 1'b0, 8'h00, 1'b1);
    reload_case(T_HDD, 32'h170, 1'b0, 8'h20, 1'b1);
    reload_case(T_HDD, 32'h1F0, 1'b0, 8'h20, 1'b0);
    for (int k = 0; k < 3; k++) begin
      cfg_wr(USR_BASE_OFS[k], 8'h10);
      cfg_wr(USR_CTL_OFS[k], 8'h83);
      reload_case(T_USR1 + k, 32'h13, 1'b0, 8'h00, 1'b1);
      reload_case(T_USR1 + k, 32'h14, 1'b0, 8'h00, 1'b0);
    end
    $display("test reload done");
  endtask : test_reload
  task test_global;
    cfg_wr(TMR_CNT_OFS[T_HDD], 8'h0A);
    cfg_wr(REG_IDLE_EN_2, 8'h01);
    repeat (25) @(negedge CLOCK);
    cfg_wr(REG_ENABLE_1, 8'h00);
    wait_smi(60, hit); check(8'(hit), 8'h00, "gated timers stop");
    cfg_wr(REG_ENABLE_1, 8'h01);
    wait_smi(28, hit); check(8'(hit), 8'h01, "resume from held count");
    cfg_wr(REG_IDLE_EN_2, 8'h00);
    $display("test global done");
  endtask : test_global
  task trap_case(input logic [7:0] dev, input logic aud, input logic exp);
    @(negedge CLOCK);
    DEVICE_TRAP_HIT = dev;
    AUDIO_TRAP_HIT  = aud;
    @(negedge CLOCK);
    DEVICE_TRAP_HIT = 8'h00;
    AUDIO_TRAP_HIT  = 1'b0;
    check(8'(TRAP_SMI), 8'(exp), "trap smi");
  endtask : trap_case
  task test_traps;
    check(8'(TRAPS_ENABLED), 8'h00, "traps off");
    trap_case(8'h04, 1'b0, 1'b0);
    trap_case(8'h00, 1'b1, 1'b1);
    cfg_wr(REG_ENABLE_1, 8'h03);
    check(8'(TRAPS_ENABLED), 8'h01, "traps on");
    trap_case(8'h80, 1'b0, 1'b1);
    cfg_wr(REG_ENABLE_1, 8'h00);
    $display("test traps done");
  endtask : test_traps
  task spd_case(input logic exp);
    repeat (3) @(negedge CLOCK);
    check(8'(THROTTLE_HOLD), 8'(exp), "hold starts");
    repeat (20) @(negedge CLOCK);
    check(8'(THROTTLE_HOLD), 8'h00, "hold ends");
  endtask : spd_case
  task test_speedup;
    cfg_wr(REG_VID_SPD_CNT, 8'h02);
    cfg_wr(REG_IRQ_SPD_CNT, 8'h02);
    pmit_host_model_i.access(32'h0, 1'b1, 1'b1);
    spd_case(1'b0);
    cfg_wr(REG_ENABLE_1, 8'h10);
    pmit_host_model_i.access(32'h0, 1'b1, 1'b1);
    spd_case(1'b1);
    pmit_host_model_i.access(32'h000A_0000, 1'b0, 1'b0);
    spd_case(1'b1);
    pmit_host_model_i.access(32'h3D4, 1'b1, 1'b0);
    spd_case(1'b1);
    cfg_wr(REG_ENABLE_1, 8'h08);
    IRQ_LINES = 16'h0008;
    spd_case(1'b0);
    IRQ_LINES = 16'h0000;
    IRQ_MASK  = 16'hFFF7;
    @(negedge CLOCK);
    IRQ_LINES = 16'h0008;
    spd_case(1'b1);
    IRQ_LINES  = 16'h0000;
    @(negedge CLOCK);
    SMI_ACTIVE = 1'b1;
    spd_case(1'b1);
    SMI_ACTIVE = 1'b0;
    cfg_wr(REG_ENABLE_1, 8'h00);
    $display("test speedup done");
  endtask : test_speedup
  // ----------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (100000) @(posedge CLOCK);
    mismatches++;
    print_verdict();
  end
  initial begin
    mismatches      = 0;
    n_tests         = 0;
    NRST            = 1'b0;
    CFG_ADDR        = 8'h00;
    CFG_WDATA       = 8'h00;
    CFG_WR          = 1'b0;
    CFG_RD          = 1'b0;
    IRQ_LINES       = 16'h0000;
    IRQ_MASK        = 16'hFFFF;
    SMI_ACTIVE      = 1'b0;
    DEVICE_TRAP_HIT = 8'h00;
    AUDIO_TRAP_HIT  = 1'b0;
    repeat (12) @(posedge CLOCK);
    @(negedge CLOCK);
    NRST = 1'b1;
    test_regs();
    test_expiry();
    test_reload();
    test_global();
    test_traps();
    test_speedup();
    print_verdict();
  end
endmodule : pm_idle_timer_enables_test

/* tb/pmit_host_model.sv */
// pmit_host_model: host side making i/o, memory and serial status traffic
// assumes: driven at falling edge, design samples at rising edge
`timescale 1ns/1ps
module pmit_host_model (
  // clock and smi
  input  wire logic  clock,
  input  wire logic  idle_smi,
  // access monitor
  output logic        acc_valid,
  output logic        acc_io,
  output logic [31:0] acc_addr,
  output logic        ser_valid,
  output logic [7:0]  ser_status
);
  int n_idle_smi;
  initial begin
    n_idle_smi = 0;
    acc_valid  = 1'b0;
    acc_io     = 1'b0;
    acc_addr   = 32'h0000_0000;
    ser_valid  = 1'b0;
    ser_status = 8'h00;
  end
  always @(posedge clock) begin
    if (idle_smi === 1'b1) n_idle_smi <= n_idle_smi + 1;
  end
  // one access pulse; released lines show the inverse
  task access(input logic [31:0] a, input logic io, input logic ser);
    @(negedge clock);
    if (ser) begin
      ser_valid  = 1'b1;
      ser_status = 8'h01;
    end else begin
      acc_valid = 1'b1;
      acc_io    = io;
      acc_addr  = a;
    end
    @(negedge clock);
    acc_valid  = 1'b0;
    ser_valid  = 1'b0;
    acc_addr   = ~a;
    ser_status = ~ser_status;
  endtask : access
endmodule : pmit_host_model
